// ==== hdl/tcs_controller.sv ====
// termination calibration sequencer: fabric end that runs a user-mode sequence
// assumes the device end samples pins on each rising edge of calUserClock
`timescale 1ns/1ps
module tcs_controller #(
  parameter int NB = tcs_pkg::NUM_BLOCKS,
  parameter int NK = tcs_pkg::NUM_BANKS
) (
  input  wire logic                         sys_clk,    // system clock
  input  wire logic                         reset,      // sync reset
  tcs_if.ctrl                               link,       // pins to device
  input  wire logic                         start,      // begin a sequence
  input  wire logic [NB-1:0]                blockMask,  // blocks to run
  input  wire logic                         seriesOnly, // short calibration
  input  wire logic [NK*tcs_pkg::BLK_W-1:0] bankSource, // block feeding bank
  output logic                              busy,       // sequence running
  output logic                              done,       // sequence finished
  output logic      [NK-1:0]                bankIoHold  // bank I/O must idle
);
  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_MODE_UP   = 4'b0001,
    ST_CLEAR     = 4'b0011,
    ST_CAL       = 4'b0010,
    ST_CAL_GAP   = 4'b0110,
    ST_MODE_DN   = 4'b0111,
    ST_XFER_WAIT = 4'b0101,
    ST_SHIFT     = 4'b0100,
    ST_LOAD_GAP  = 4'b1100,
    ST_LOAD      = 4'b1101,
    ST_DONE      = 4'b1111
  } tcs_state_e;

  localparam int DIV_W = $clog2(tcs_pkg::CAL_DIV + 1);

  tcs_state_e                 state_q;
  logic [DIV_W-1:0]           divCnt_q;
  logic                       calClk_q;
  logic [tcs_pkg::CNT_W-1:0]  cnt_q;
  logic [tcs_pkg::CNT_W-1:0]  calLen_q;
  logic [tcs_pkg::BLK_W-1:0]  cur_q;
  logic [NB-1:0]              mask_q;
  logic                       mode_q;
  logic                       clrN_q;
  logic [NB-1:0]              en_q;
  logic [NK-1:0]              load_q;
  logic                       done_q;

  // lowest selected block at or above a start index
  function automatic logic [tcs_pkg::BLK_W:0] nextBlock(
    input logic [NB-1:0]         mask,
    input logic [tcs_pkg::BLK_W:0] from
  );
    logic [tcs_pkg::BLK_W:0] res;
    res = {1'b0, tcs_pkg::BLK_NONE};
    for (int i = NB - 1; i >= 0; i--) begin
      if (mask[i] && (i >= int'(from))) begin
        res = {1'b1, tcs_pkg::BLK_W'(i)};
      end
    end
    return res;
  endfunction : nextBlock

  // banks wired to the given block
  function automatic logic [NK-1:0] banksOf(
    input logic [NK*tcs_pkg::BLK_W-1:0] srcMap,
    input logic [tcs_pkg::BLK_W-1:0]    blk
  );
    logic [NK-1:0] res;
    res = '0;
    for (int k = 0; k < NK; k++) begin
      res[k] = (srcMap[k*tcs_pkg::BLK_W +: tcs_pkg::BLK_W] == blk);
    end
    return res;
  endfunction : banksOf

  // divider rounded so the rate never passes the limit
  wire lastDiv = (divCnt_q == DIV_W'(tcs_pkg::CAL_DIV - 1));
  // every control flop moves on the edge that raises the clock
  wire calRise = lastDiv;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      divCnt_q <= '0;
      calClk_q <= 1'b0;
    end else begin
      divCnt_q <= lastDiv ? '0 : divCnt_q + 1'b1;
      // high only as a continuation, so no short first pulse after reset
      calClk_q <= lastDiv || (calClk_q && (divCnt_q < DIV_W'(tcs_pkg::CAL_HIGH - 1)));
    end
  end

  wire [tcs_pkg::BLK_W:0] firstSel = nextBlock(mask_q, '0);
  wire [tcs_pkg::BLK_W:0] nextSel  = nextBlock(mask_q, {1'b0, cur_q} + 1'b1);
  wire [tcs_pkg::BLK_W:0] startSel = nextBlock(blockMask, '0);
  wire [NB-1:0]           curHot   = NB'(1) << cur_q;
  wire [NB-1:0]           nextHot  = NB'(1) << nextSel[tcs_pkg::BLK_W-1:0];
  wire                    cntHit   = (cnt_q == calLen_q);
  wire                    xferHit  = (cnt_q == tcs_pkg::CNT_W'(tcs_pkg::XFER_CYC));
  wire                    loadHit  = (cnt_q == tcs_pkg::CNT_W'(tcs_pkg::LOAD_CAL_CYC));

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q  <= ST_IDLE;
      cnt_q    <= '0;
      calLen_q <= tcs_pkg::CNT_W'(tcs_pkg::CAL_FULL_CYC);
      cur_q    <= '0;
      mask_q   <= '0;
      mode_q   <= 1'b0;
      clrN_q   <= 1'b1;
      en_q     <= '0;
      load_q   <= '0;
      done_q   <= 1'b0;
    end else if (calRise) begin
      case (state_q)
        ST_IDLE: begin
          if (start && startSel[tcs_pkg::BLK_W]) begin
            mask_q <= blockMask;
            cur_q  <= startSel[tcs_pkg::BLK_W-1:0];
            done_q <= 1'b0;
            calLen_q <= seriesOnly ? tcs_pkg::CNT_W'(tcs_pkg::CAL_SERIES_CYC)
                                   : tcs_pkg::CNT_W'(tcs_pkg::CAL_FULL_CYC);
            // mode up two cycles before any enable
            mode_q  <= 1'b1;
            state_q <= ST_MODE_UP;
          end
        end
        ST_MODE_UP: begin
          clrN_q  <= 1'b0;
          state_q <= ST_CLEAR;
        end
        ST_CLEAR: begin
          clrN_q  <= 1'b1;
          en_q    <= curHot;
          cnt_q   <= tcs_pkg::CNT_W'(1);
          state_q <= ST_CAL;
        end
        ST_CAL: begin
          // enable high for the whole length
          if (cntHit) begin
            en_q    <= '0;
            state_q <= ST_CAL_GAP;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_CAL_GAP: begin
          if (nextSel[tcs_pkg::BLK_W]) begin
            // mode kept high, clear fills the gap
            cur_q   <= nextSel[tcs_pkg::BLK_W-1:0];
            clrN_q  <= 1'b0;
            state_q <= ST_CLEAR;
          end else begin
            // mode drops a cycle after the last enable
            mode_q  <= 1'b0;
            state_q <= ST_MODE_DN;
          end
        end
        ST_MODE_DN: begin
          // a full cycle before the first transfer enable
          cur_q   <= firstSel[tcs_pkg::BLK_W-1:0];
          state_q <= ST_XFER_WAIT;
        end
        ST_XFER_WAIT: begin
          // one block shifts at a time
          en_q    <= curHot;
          cnt_q   <= tcs_pkg::CNT_W'(1);
          state_q <= ST_SHIFT;
        end
        ST_SHIFT: begin
          if (xferHit) begin
            en_q    <= '0;
            state_q <= ST_LOAD_GAP;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_LOAD_GAP: begin
          // load one cycle after the enable falls
          load_q  <= banksOf(bankSource, cur_q);
          cnt_q   <= tcs_pkg::CNT_W'(1);
          state_q <= ST_LOAD;
        end
        ST_LOAD: begin
          // held for at least 25 ns
          if (!loadHit) begin
            cnt_q <= cnt_q + 1'b1;
          end else begin
            load_q <= '0;
            if (nextSel[tcs_pkg::BLK_W]) begin
              // enable low through gap and load
              cur_q   <= nextSel[tcs_pkg::BLK_W-1:0];
              en_q    <= nextHot;
              cnt_q   <= tcs_pkg::CNT_W'(1);
              state_q <= ST_SHIFT;
            end else begin
              done_q  <= 1'b1;
              state_q <= ST_DONE;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign link.calUserClock     = calClk_q;
  assign link.calModeSelect    = mode_q;
  assign link.calClearN        = clrN_q;
  assign link.blockCalEnable   = en_q;
  assign link.bankParallelLoad = load_q;
  assign busy                  = (state_q != ST_IDLE);
  assign done                  = done_q;
  // user logic keeps these banks quiet
  assign bankIoHold            = load_q;
endmodule : tcs_controller

// ==== hdl/tcs_pkg.sv ====
// termination calibration sequencer: shared constants for both ends
// assumes one system clock of 125 MHz; the calibration clock is derived from it
package tcs_pkg;
  localparam int NUM_BLOCKS      = 10;
  localparam int NUM_BANKS       = 16;
  localparam int CODE_BITS       = 28;
  localparam int HALF_BITS       = 14;
  localparam int BLK_W           = 4;
  localparam int CNT_W           = 10;
  localparam int SYS_FREQ_HZ     = 125_000_000;
  localparam int SYS_PERIOD_NS   = 8;
  localparam int CAL_CLK_MAX_HZ  = 20_000_000;
  // fastest clock allowed must not be exceeded, so divide rounds up
  localparam int CAL_DIV         = (SYS_FREQ_HZ + CAL_CLK_MAX_HZ - 1) / CAL_CLK_MAX_HZ;
  localparam int CAL_HIGH        = CAL_DIV / 2;
  localparam int CAL_FULL_CYC    = 1000;
  localparam int CAL_SERIES_CYC  = 240;
  localparam int XFER_CYC        = 28;
  localparam int LOAD_MIN_NS     = 25;
  localparam int LOAD_SYS_CYC    = (LOAD_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int LOAD_CAL_RAW    = (LOAD_SYS_CYC + CAL_DIV - 1) / CAL_DIV;
  localparam int LOAD_CAL_CYC    = (LOAD_CAL_RAW < 1) ? 1 : LOAD_CAL_RAW;
  localparam logic [BLK_W-1:0] BLK_NONE = 4'hF;
endpackage : tcs_pkg

// ==== hdl/tcs_if.sv ====
// termination calibration sequencer: wires between fabric logic and device
// assumes both ends sit on sys_clk; calUserClock is a divided level, not a clock
`timescale 1ns/1ps
interface tcs_if #(
  parameter int NB = tcs_pkg::NUM_BLOCKS,
  parameter int NK = tcs_pkg::NUM_BANKS
);
  logic          calUserClock;     // divided calibration clock level
  logic          calModeSelect;    // 1 calibrate, 0 serial transfer
  logic          calClearN;        // active-low clear
  logic [NB-1:0] blockCalEnable;   // one enable per block
  logic [NK-1:0] bankParallelLoad; // one load per bank

  modport ctrl (output calUserClock, calModeSelect, calClearN, blockCalEnable,
                bankParallelLoad);
  modport dev  (input  calUserClock, calModeSelect, calClearN, blockCalEnable,
                bankParallelLoad);
endinterface : tcs_if

// ==== hdl/tcs_cal_block.sv ====
// termination calibration sequencer: one calibration block
// assumes calRise marks a calibration clock edge and inputs are pre-edge values
`timescale 1ns/1ps
module tcs_cal_block (
  input  wire logic                          sys_clk,    // system clock
  input  wire logic                          reset,      // sync reset
  input  wire logic                          calRise,    // cal clock edge
  input  wire logic                          modeSel,    // cal / transfer
  input  wire logic                          clearN,     // active-low clear
  input  wire logic                          enable,     // this block's enable
  input  wire logic [tcs_pkg::CODE_BITS-1:0] measCode,   // comparator result
  output logic                               seriesDone, // series half valid
  output logic                               fullDone,   // both halves valid
  output logic                               serBit,     // serial code bit
  output logic                               serValid    // bit strobe
);
  logic [tcs_pkg::CNT_W-1:0]     cnt_q;
  logic [tcs_pkg::CODE_BITS-1:0] code_q;
  logic [tcs_pkg::CODE_BITS-1:0] shift_q;
  logic                          seriesDone_q;
  logic                          fullDone_q;
  wire  calibrating = modeSel & enable;
  wire  shifting    = ~modeSel & enable;
  wire  hitSeries   = (cnt_q == tcs_pkg::CNT_W'(tcs_pkg::CAL_SERIES_CYC - 1));
  wire  hitFull     = (cnt_q == tcs_pkg::CNT_W'(tcs_pkg::CAL_FULL_CYC - 1));

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnt_q        <= '0;
      seriesDone_q <= 1'b0;
      fullDone_q   <= 1'b0;
    // clear resets only a block not calibrating
    end else if (calRise && !clearN && !calibrating) begin
      cnt_q        <= '0;
      seriesDone_q <= 1'b0;
      fullDone_q   <= 1'b0;
    end else if (calRise && calibrating) begin
      if (!hitFull) begin
        cnt_q <= cnt_q + 1'b1;
      end
      if (hitSeries) begin
        seriesDone_q <= 1'b1;
      end
      if (hitFull) begin
        fullDone_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      code_q <= '0;
    end else if (calRise && calibrating) begin
      if (hitSeries) begin
        code_q[tcs_pkg::CODE_BITS-1:tcs_pkg::HALF_BITS] <=
          measCode[tcs_pkg::CODE_BITS-1:tcs_pkg::HALF_BITS];
      end
      if (hitFull) begin
        code_q[tcs_pkg::HALF_BITS-1:0] <= measCode[tcs_pkg::HALF_BITS-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      shift_q <= '0;
    end else if (calRise) begin
      shift_q <= shifting ? {shift_q[tcs_pkg::CODE_BITS-2:0], 1'b0} : code_q;
    end
  end

  assign seriesDone = seriesDone_q;
  assign fullDone   = fullDone_q;
  assign serBit     = shift_q[tcs_pkg::CODE_BITS-1];
  assign serValid   = calRise & shifting;
endmodule : tcs_cal_block

// ==== hdl/tcs_device.sv ====
// termination calibration sequencer: device end (blocks, banks, power-up run)
// assumes the fabric end keeps calUserClock toggling from reset onward
`timescale 1ns/1ps
module tcs_device #(
  parameter int NB = tcs_pkg::NUM_BLOCKS,
  parameter int NK = tcs_pkg::NUM_BANKS
) (
  input  wire logic                                sys_clk,    // system clock
  input  wire logic                                reset,      // sync reset
  tcs_if.dev                                       link,       // fabric control
  input  wire logic [NB*tcs_pkg::CODE_BITS-1:0]    measCode,   // per-block result
  input  wire logic [NK*tcs_pkg::BLK_W-1:0]        bankSource, // block feeding bank
  output logic      [NK*tcs_pkg::CODE_BITS-1:0]    bankCode,   // active bank codes
  output logic      [NB-1:0]                       blockDone,  // full cal done
  output logic                                     userMode    // power-up run over
);
  typedef enum logic [1:0] {
    PU_CAL = 2'b00, PU_SHIFT = 2'b01, PU_LOAD = 2'b11, PU_USER = 2'b10
  } tcs_pu_e;

  tcs_pu_e                   puState_q;
  logic [tcs_pkg::CNT_W-1:0] puCnt_q;
  logic                      clkPrev_q, modePrev_q, clrPrev_q;
  logic [NB-1:0]             enPrev_q;
  logic [NK-1:0]             loadPrev_q;
  logic [NB-1:0]             serBit, serValid;
  logic [tcs_pkg::CODE_BITS-1:0] bankShift_q [NK];
  logic [tcs_pkg::CODE_BITS-1:0] bankCode_q  [NK];

  // edge seen with the values that stood before it
  wire calRise  = link.calUserClock & ~clkPrev_q;
  wire inUser   = (puState_q == PU_USER);
  // power-up run overrides the fabric pins
  wire effMode  = inUser ? modePrev_q : (puState_q == PU_CAL);
  wire effClrN  = inUser ? clrPrev_q  : 1'b1;
  wire [NB-1:0] effEn   = inUser ? enPrev_q : {NB{puState_q != PU_LOAD}};
  wire [NK-1:0] effLoad = inUser ? loadPrev_q : {NK{puState_q == PU_LOAD}};
  wire puLast = (puState_q == PU_CAL   && puCnt_q == tcs_pkg::CNT_W'(tcs_pkg::CAL_FULL_CYC))
             || (puState_q == PU_SHIFT && puCnt_q == tcs_pkg::CNT_W'(tcs_pkg::XFER_CYC - 1))
             || (puState_q == PU_LOAD  && puCnt_q == tcs_pkg::CNT_W'(tcs_pkg::LOAD_CAL_CYC - 1));

  always_ff @(posedge sys_clk) begin
    clkPrev_q  <= reset ? 1'b0 : link.calUserClock;
    modePrev_q <= reset ? 1'b0 : link.calModeSelect;
    clrPrev_q  <= reset ? 1'b1 : link.calClearN;
    enPrev_q   <= reset ? '0   : link.blockCalEnable;
    loadPrev_q <= reset ? '0   : link.bankParallelLoad;
  end

  // calibrate, shift, load, then user mode
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      puState_q <= PU_CAL;
      puCnt_q   <= '0;
    end else if (calRise && !inUser) begin
      puCnt_q <= puLast ? '0 : puCnt_q + 1'b1;
      if (puLast) begin
        case (puState_q)
          PU_CAL:   puState_q <= PU_SHIFT;
          PU_SHIFT: puState_q <= PU_LOAD;
          default:  puState_q <= PU_USER;
        endcase
      end
    end
  end

  // mode and clear shared, enables private
  for (genvar b = 0; b < NB; b++) begin : g_blk
    tcs_cal_block u_blk (
      .sys_clk    (sys_clk),
      .reset      (reset),
      .calRise    (calRise),
      .modeSel    (effMode),
      .clearN     (effClrN),
      .enable     (effEn[b]),
      .measCode   (measCode[b*tcs_pkg::CODE_BITS +: tcs_pkg::CODE_BITS]),
      .seriesDone (),
      .fullDone   (blockDone[b]),
      .serBit     (serBit[b]),
      .serValid   (serValid[b])
    );
  end

  // any bank may take any block's code
  for (genvar k = 0; k < NK; k++) begin : g_bank
    wire [tcs_pkg::BLK_W-1:0] src = bankSource[k*tcs_pkg::BLK_W +: tcs_pkg::BLK_W];
    wire srcOk = (int'(src) < NB);
    always_ff @(posedge sys_clk) begin
      if (reset) begin
        bankShift_q[k] <= '0;
        bankCode_q[k]  <= '0;
      end else begin
        if (srcOk && serValid[src]) begin
          bankShift_q[k] <= {bankShift_q[k][tcs_pkg::CODE_BITS-2:0], serBit[src]};
        end
        // own load makes the code parallel
        if (calRise && effLoad[k]) begin
          bankCode_q[k] <= bankShift_q[k];
        end
      end
    end
    assign bankCode[k*tcs_pkg::CODE_BITS +: tcs_pkg::CODE_BITS] = bankCode_q[k];
  end

  assign userMode = inUser;
endmodule : tcs_device

// ==== bench/tcs_link_sva.sv ====
// checker for the link between fabric controller and calibration device
// assumes every pin is a sys_clk flop and a cal edge is a rise of calUserClock
`timescale 1ns/1ps
module tcs_link_sva #(
  parameter int NB = tcs_pkg::NUM_BLOCKS,
  parameter int NK = tcs_pkg::NUM_BANKS
) (
  input wire logic          sys_clk,          // system clock
  input wire logic          reset,            // sync reset
  input wire logic          calUserClock,     // divided cal clock
  input wire logic          calModeSelect,    // calibrate or transfer
  input wire logic          calClearN,        // active-low clear
  input wire logic [NB-1:0] blockCalEnable,   // per-block enable
  input wire logic [NK-1:0] bankParallelLoad  // per-bank load
);
  localparam int DIV     = tcs_pkg::CAL_DIV;
  localparam int FULL_SC = tcs_pkg::CAL_FULL_CYC * DIV;
  localparam int SER_SC  = tcs_pkg::CAL_SERIES_CYC * DIV;
  localparam int XFER_SC = tcs_pkg::XFER_CYC * DIV;

  wire        anyEn   = |blockCalEnable;
  wire        anyLoad = |bankParallelLoad;
  logic [15:0] enCnt_q;
  logic [15:0] enCnt_d;

  // counts sys cycles of one enable pulse; the longest, 7000, fits in 16 bits
  assign enCnt_d = anyEn ? enCnt_q + 16'h0001 : 16'h0000;
  always_ff @(posedge sys_clk) begin
    if (reset) enCnt_q <= 16'h0000;
    else enCnt_q <= enCnt_d;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  clk_period_a: assert property (
    $rose(calUserClock) |-> calUserClock[*3] ##1 (!calUserClock)[*4] ##1 calUserClock)
    else $error("cal clock period or duty wrong");
  pins_sync_a: assert property (
    !$rose(calUserClock) |->
      $stable({calModeSelect, calClearN, blockCalEnable, bankParallelLoad}))
    else $error("control pin moved off a cal edge");
  cal_lead_a: assert property (
    $rose(anyEn) && calModeSelect |-> $past(calModeSelect, 7))
    else $error("enable rose without mode lead");
  clear_pulse_a: assert property (
    $rose(anyEn) && calModeSelect |-> !$past(calClearN) && calClearN)
    else $error("no clear pulse before enable");
  cal_length_a: assert property (
    $fell(anyEn) && calModeSelect |-> enCnt_q == FULL_SC || enCnt_q == SER_SC)
    else $error("calibration enable length wrong");
  mode_drop_a: assert property (
    $fell(calModeSelect) |-> !anyEn && !$past(anyEn, 7))
    else $error("mode dropped during calibration");
  xfer_onehot_a: assert property (
    !calModeSelect |-> $onehot0(blockCalEnable))
    else $error("several enables in transfer");
  xfer_lead_a: assert property (
    $rose(anyEn) && !calModeSelect |-> !$past(calModeSelect, 7))
    else $error("transfer began too soon after mode drop");
  xfer_length_a: assert property (
    $fell(anyEn) && !calModeSelect |-> enCnt_q == XFER_SC)
    else $error("transfer enable length wrong");
  enable_gap_a: assert property (
    $fell(anyEn) |-> (!anyEn)[*7])
    else $error("no gap between enables");
  load_timing_a: assert property (
    $rose(anyLoad) |-> !$past(anyEn, 7) && $past(anyEn, 14) ##0 anyLoad[*7] ##1 !anyLoad)
    else $error("bank load timing wrong");
endmodule : tcs_link_sva

// ==== bench/tb.sv ====
// self-checking bench: controller and device joined by one link
// assumes both ends share sys_clk and bankSource feeds both ends alike
`timescale 1ns/1ps
module tb;
  localparam int NB    = tcs_pkg::NUM_BLOCKS;
  localparam int NK    = tcs_pkg::NUM_BANKS;
  localparam int CB    = tcs_pkg::CODE_BITS;
  localparam int DIV   = tcs_pkg::CAL_DIV;
  localparam int W     = NK * CB;
  localparam int LIMIT = 60000;
  typedef struct {
    logic [NB-1:0] mask;
    logic          so;
    int            gen;
  } tcs_row_s;

  logic             sys_clk;
  logic             reset;
  logic             start;
  logic             seriesOnly;
  logic [NB-1:0]    blockMask;
  logic [NB*CB-1:0] measCode;
  logic [NK*4-1:0]  bankSource;
  logic [W-1:0]     bankCode;
  logic [W-1:0]     expCode;
  logic [NB-1:0]    blockDone;
  logic             userMode;
  logic             busy;
  logic             done;
  logic [NK-1:0]    bankIoHold;
  int               num_errors;
  int               n_tests;
  int               cycles = 0;
  tcs_row_s         rows [3] = '{'{10'h001, 1'b0, 1}, '{10'h006, 1'b1, 2}, '{10'h200, 1'b0, 3}};

  tcs_if #(.NB(NB), .NK(NK)) link ();
  tcs_controller #(.NB(NB), .NK(NK)) tcs_controller_inst (
    .sys_clk(sys_clk), .reset(reset), .link(link), .start(start), .blockMask(blockMask),
    .seriesOnly(seriesOnly), .bankSource(bankSource), .busy(busy), .done(done),
    .bankIoHold(bankIoHold));
  tcs_device #(.NB(NB), .NK(NK)) tcs_device_inst (
    .sys_clk(sys_clk), .reset(reset), .link(link), .measCode(measCode),
    .bankSource(bankSource), .bankCode(bankCode), .blockDone(blockDone), .userMode(userMode));
  tcs_link_sva #(.NB(NB), .NK(NK)) tcs_link_sva_inst (
    .sys_clk(sys_clk), .reset(reset), .calUserClock(link.calUserClock),
    .calModeSelect(link.calModeSelect), .calClearN(link.calClearN),
    .blockCalEnable(link.blockCalEnable), .bankParallelLoad(link.bankParallelLoad));

  initial begin
    sys_clk = 1'b0;
    forever #(tcs_pkg::SYS_PERIOD_NS / 2) sys_clk = ~sys_clk;
  end

  // banks 14 and 15 have no source, so the controller must never load them
  function automatic logic [3:0] src_of(int k);
    return (k < NB) ? 4'(k) : (k < 14) ? 4'(k - NB) : 4'hF;
  endfunction : src_of
  function automatic logic [CB-1:0] code_of(int b, int gen);
    return CB'(32'h05A3_C96E ^ (32'h0011_1111 * b) ^ (32'h08C0_0003 * gen));
  endfunction : code_of
  function automatic logic [NK-1:0] banks_of(int b);
    for (int k = 0; k < NK; k++) banks_of[k] = (src_of(k) == 4'(b));
  endfunction : banks_of

  task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      close_out();
    end
  end

  task automatic set_codes(input int gen);
    for (int b = 0; b < NB; b++) measCode[b*CB +: CB] <= code_of(b, gen);
  endtask : set_codes

  // series-only run refreshes the upper half and keeps the held lower half
  task automatic expect_run(input logic [NB-1:0] m, input logic so, input int gen);
    logic [3:0]    s;
    logic [CB-1:0] c;
    for (int k = 0; k < NK; k++) begin
      s = src_of(k);
      c = code_of(int'(s), gen);
      if (s < NB && m[s]) begin
        if (so) expCode[k*CB+14 +: 14] = c[CB-1:14];
        else expCode[k*CB +: CB] = c;
      end
    end
  endtask : expect_run

  task automatic power_up(input int gen);
    int i;
    set_codes(gen);
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    check(W'({busy, done, userMode, blockDone, bankIoHold, link.calUserClock, link.calModeSelect,
              !link.calClearN, link.blockCalEnable, link.bankParallelLoad}), '0);
    check(bankCode, '0);
    for (i = 0; i < 9000 && userMode !== 1'b1; i++) @(posedge sys_clk);
    repeat (DIV) @(posedge sys_clk);
    expCode = '0;
    expect_run({NB{1'b1}}, 1'b0, gen);
    check(W'(userMode), W'(1'b1));
    check(bankCode, expCode);
  endtask : power_up

  task automatic run_seq(input tcs_row_s r);
    int i;
    int cnt;
    int lenCal;
    int blk;
    blk = 0;
    set_codes(r.gen);
    start <= 1'b1;
    blockMask <= r.mask;
    seriesOnly <= r.so;
    cnt = 0;
    for (i = 0; i < 20000 && !(cnt > 0 && busy === 1'b0); i++) begin
      @(posedge sys_clk);
      if (busy === 1'b1) cnt++;
      // a new request while busy must be ignored
      if (cnt == 14) blockMask <= ~r.mask;
      if (cnt == 14) seriesOnly <= ~r.so;
      if (cnt == 28) start <= 1'b0;
      if (|link.blockCalEnable) blk = $clog2(link.blockCalEnable);
      if (|link.bankParallelLoad || |bankIoHold) check(W'(bankIoHold), W'(banks_of(blk)));
    end
    lenCal = 4 + $countones(r.mask) * ((r.so ? tcs_pkg::CAL_SERIES_CYC : tcs_pkg::CAL_FULL_CYC)
             + 4 + tcs_pkg::XFER_CYC);
    check(W'(cnt), W'(lenCal * DIV));
    check(W'(done), W'(1'b1));
    check(W'(blockDone & r.mask), W'(r.so ? {NB{1'b0}} : r.mask));
    expect_run(r.mask, r.so, r.gen);
    check(bankCode, expCode);
  endtask : run_seq

  initial begin
    reset = 1'b1;
    start = 1'b0;
    blockMask = '0;
    seriesOnly = 1'b0;
    measCode = '0;
    expCode = '0;
    num_errors = 0;
    n_tests = 0;
    for (int k = 0; k < NK; k++) bankSource[k*4 +: 4] = src_of(k);
    @(posedge sys_clk);
    power_up(0);
    foreach (rows[i]) run_seq(rows[i]);
    // empty mask is refused
    start <= 1'b1;
    blockMask <= '0;
    repeat (3 * DIV) @(posedge sys_clk);
    check(W'(busy), W'(1'b0));
    start <= 1'b0;
    // reset in mid-calibration must restart cleanly
    @(posedge sys_clk);
    start <= 1'b1;
    blockMask <= 10'h010;
    repeat (500) @(posedge sys_clk);
    check(W'(busy), W'(1'b1));
    start <= 1'b0;
    power_up(5);
    close_out();
  end
endmodule : tb
